// File: logic/ctm_pkg.sv
// constants and carriers for the match/capture counter-timer block
// Functional notes
// RULE1 - four instances: two 32-bit and two 16-bit, all from one parameterised core
// RULE2 - timer counts core clocks; a prescaler as wide as the counter sets cycles per step
// RULE3 - each instance selects timer mode or counting edges of an external input
// RULE4 - four match values per instance; a match may just raise its interrupt flag
// RULE5 - stop-on-match halts the counter at that value, optional interrupt flag
// RULE6 - reset-on-match returns the counter to zero, optional interrupt flag
// RULE7 - one output per match: drive low, drive high, toggle or leave unchanged
// RULE8 - a selected capture input edge copies the count into the capture value
// RULE9 - a capture event sets the capture interrupt flag when software enables it
// RULE10 - a designated capture edge clears both counter and prescaler
// RULE11 - match is seen on the prescaled tick; flags stay set until software clears them
// RULE12 - without stop or reset on match the counter wraps from maximum to zero
package ctm_pkg;
  localparam int NUM_TMR = 4;
  localparam int NUM_MATCH = 4;
  // byte offsets inside one timer's 64-byte window; address bits 7:6 pick the timer
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_FLAGS = 6'h04;
  localparam logic [5:0] OFS_COUNT = 6'h08;
  localparam logic [5:0] OFS_PRESC = 6'h0c;
  localparam logic [5:0] OFS_MATCH0 = 6'h10;
  localparam logic [5:0] OFS_MCTRL = 6'h20;
  localparam logic [5:0] OFS_EXTC = 6'h24;
  localparam logic [5:0] OFS_CAPC = 6'h28;
  localparam logic [5:0] OFS_CAPTURE = 6'h2c;
  localparam logic [5:0] OFS_PCOUNT = 6'h30;
  // control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_CNTMODE = 2;
  localparam int CTRL_RISE = 3;
  localparam int CTRL_FALL = 4;
  localparam int CTRL_HALT = 5;
  // match control: three bits per match
  localparam int MC_IRQ = 0;
  localparam int MC_RST = 1;
  localparam int MC_STOP = 2;
  localparam int MC_STRIDE = 3;
  // output action: two bits per match above the output state bits
  localparam int EXT_ACT = 4;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // capture control
  localparam int CAP_RISE = 0;
  localparam int CAP_FALL = 1;
  localparam int CAP_IRQ = 2;
  localparam int CLR_RISE = 3;
  localparam int CLR_FALL = 4;
  localparam int FLAG_CAP = 4;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [4:0] RST_CTRL = 5'h00;

  typedef struct packed {
    logic [4:0] ctrl;
    logic [31:0] prescale;
    logic [11:0] mctrl;
    logic [7:0] act;
    logic [4:0] capc;
    logic [3:0][31:0] match;
  } cfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_t;
endpackage : ctm_pkg

// File: logic/ctm_unit.sv
// one counter/timer core, width set by parameter
`timescale 1ns/10ps
module ctm_unit #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration and software strobes
  input wire ctm_pkg::cfg_t cfg,
  input wire logic wr_cnt,
  input wire logic wr_ext,
  input wire logic wr_ctrl,
  input wire logic [4:0] clr_flags,
  input wire logic [31:0] wdata,
  // synchronised pin edges
  input wire ctm_pkg::edge_t cnt_edge,
  input wire ctm_pkg::edge_t cap_edge,
  // state
  output logic [31:0] cnt,
  output logic [31:0] pcnt,
  output logic [31:0] capt,
  output logic [4:0] flags,
  output logic [3:0] mout,
  output logic halted,
  output logic tick,
  output logic [3:0] mhit
);
  import ctm_pkg::*;

  logic [W-1:0] tc, next_tc, pc, next_pc, cv, next_cv;
  logic [4:0] next_flags;
  logic [3:0] next_mout;
  logic next_halted;
  logic run, cap_ev, clr_ev;
  logic [3:0] rst_hit, stop_hit;

  assign run = cfg.ctrl[CTRL_EN] & ~cfg.ctrl[CTRL_HOLD] & ~halted;
  // counter mode steps on pin edges, timer mode on prescaler roll-over
  assign tick = cfg.ctrl[CTRL_CNTMODE] ?
    run & ((cfg.ctrl[CTRL_RISE] & cnt_edge.rise) | (cfg.ctrl[CTRL_FALL] & cnt_edge.fall)) : // see RULE3
    run & (pc == cfg.prescale[W-1:0]); // see RULE2
  assign cap_ev = (cfg.capc[CAP_RISE] & cap_edge.rise) | (cfg.capc[CAP_FALL] & cap_edge.fall);
  assign clr_ev = (cfg.capc[CLR_RISE] & cap_edge.rise) | (cfg.capc[CLR_FALL] & cap_edge.fall);

  for (genvar i = 0; i < NUM_MATCH; i++) begin : g_match
    assign mhit[i] = tick & (tc == cfg.match[i][W-1:0]); // see RULE11
    assign rst_hit[i] = mhit[i] & cfg.mctrl[i*MC_STRIDE+MC_RST];
    assign stop_hit[i] = mhit[i] & cfg.mctrl[i*MC_STRIDE+MC_STOP];
  end

  always_comb begin
    next_flags = flags & ~clr_flags;
    next_cv = cv;
    next_mout = mout;
    // a stop landing with a control write still halts
    next_halted = halted & ~wr_ctrl;
    next_pc = pc;
    next_tc = tc;
    if (run && !cfg.ctrl[CTRL_CNTMODE]) begin
      next_pc = tick ? '0 : pc + 1'b1; // see RULE2
    end
    if (tick) begin
      // stop wins over reset when both hit on one tick
      if (|stop_hit) begin
        next_halted = 1'b1; // see RULE5
      end else if (|rst_hit) begin
        next_tc = '0; // see RULE6
      end else begin
        next_tc = tc + 1'b1; // see RULE12
      end
    end
    for (int i = 0; i < NUM_MATCH; i++) begin
      if (mhit[i] && cfg.mctrl[i*MC_STRIDE+MC_IRQ]) begin
        next_flags[i] = 1'b1; // see RULE4
      end
      if (mhit[i]) begin
        case (cfg.act[2*i +: 2])
          ACT_LOW: next_mout[i] = 1'b0; // see RULE7
          ACT_HIGH: next_mout[i] = 1'b1;
          ACT_TOGGLE: next_mout[i] = ~mout[i];
          default: next_mout[i] = mout[i];
        endcase
      end
    end
    if (cap_ev) begin
      next_cv = tc; // see RULE8
      if (cfg.capc[CAP_IRQ]) begin
        next_flags[FLAG_CAP] = 1'b1; // see RULE9
      end
    end
    if (clr_ev) begin
      next_tc = '0; // see RULE10
      next_pc = '0;
    end
    if (wr_cnt) begin
      next_tc = wdata[W-1:0];
      next_pc = '0;
    end
    if (wr_ext) begin
      next_mout = wdata[3:0];
    end
    if (cfg.ctrl[CTRL_HOLD]) begin
      next_tc = '0;
      next_pc = '0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tc <= '0;
      pc <= '0;
      cv <= '0;
      flags <= '0;
      mout <= '0;
      halted <= 1'b0;
    end else begin
      tc <= next_tc;
      pc <= next_pc;
      cv <= next_cv;
      flags <= next_flags;
      mout <= next_mout;
      halted <= next_halted;
    end
  end

  // narrow instances read zero above their width
  assign cnt = 32'(tc);
  assign pcnt = 32'(pc);
  assign capt = 32'(cv);
endmodule : ctm_unit

// File: logic/ctm_top.sv
// four counter/timers behind a plain register port
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module ctm_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins
  input wire logic [3:0] cnt_pin,
  input wire logic [3:0] cap_pin,
  output logic [15:0] match_out,
  output logic [3:0] irq
);
  import ctm_pkg::*;

  logic [1:0] tsel;
  logic [5:0] off;
  logic [4:0] ctrl [NUM_TMR];
  logic [4:0] next_ctrl [NUM_TMR];
  logic [31:0] presc [NUM_TMR];
  logic [31:0] next_presc [NUM_TMR];
  logic [11:0] mctrl [NUM_TMR];
  logic [11:0] next_mctrl [NUM_TMR];
  logic [7:0] act [NUM_TMR];
  logic [7:0] next_act [NUM_TMR];
  logic [4:0] capc [NUM_TMR];
  logic [4:0] next_capc [NUM_TMR];
  logic [3:0][31:0] match [NUM_TMR];
  logic [3:0][31:0] next_match [NUM_TMR];
  logic [31:0] cnt [NUM_TMR];
  logic [31:0] pcnt [NUM_TMR];
  logic [31:0] capt [NUM_TMR];
  logic [4:0] flags [NUM_TMR];
  logic [3:0] mout [NUM_TMR];
  logic [NUM_TMR-1:0] halted, tick;
  logic [3:0] mhit [NUM_TMR];
  logic [3:0] cnt_s1, cnt_s2, cnt_prev, cap_s1, cap_s2, cap_prev;
  logic [31:0] next_rdata;
  logic [3:0] next_irq;
  logic narrow;

  assign tsel = addr[7:6];
  assign off = addr[5:0];
  // timers 2 and 3 store 32 bits but only the low half is theirs
  assign narrow = tsel[1];

  // two-stage synchronisers; edges read only the second stage
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_s1 <= 4'h0;
      cnt_s2 <= 4'h0;
      cnt_prev <= 4'h0;
      cap_s1 <= 4'h0;
      cap_s2 <= 4'h0;
      cap_prev <= 4'h0;
    end else begin
      cnt_s1 <= cnt_pin;
      cnt_s2 <= cnt_s1;
      cnt_prev <= cnt_s2;
      cap_s1 <= cap_pin;
      cap_s2 <= cap_s1;
      cap_prev <= cap_s2;
    end
  end

  // register writes
  always_comb begin
    for (int t = 0; t < NUM_TMR; t++) begin
      next_ctrl[t] = ctrl[t];
      next_presc[t] = presc[t];
      next_mctrl[t] = mctrl[t];
      next_act[t] = act[t];
      next_capc[t] = capc[t];
      next_match[t] = match[t];
    end
    if (wr) begin
      case (off)
        OFS_CTRL: next_ctrl[tsel] = wdata[4:0];
        OFS_PRESC: next_presc[tsel] = wdata;
        OFS_MCTRL: next_mctrl[tsel] = wdata[11:0];
        OFS_EXTC: next_act[tsel] = wdata[EXT_ACT +: 8];
        OFS_CAPC: next_capc[tsel] = wdata[4:0];
        default: begin
          if (off[5:4] == OFS_MATCH0[5:4]) begin
            next_match[tsel][off[3:2]] = wdata;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int t = 0; t < NUM_TMR; t++) begin
        ctrl[t] <= RST_CTRL;
        presc[t] <= RST_WORD;
        mctrl[t] <= 12'h000;
        act[t] <= 8'h00;
        capc[t] <= 5'h00;
        match[t] <= '0;
      end
    end else begin
      for (int t = 0; t < NUM_TMR; t++) begin
        ctrl[t] <= next_ctrl[t];
        presc[t] <= next_presc[t];
        mctrl[t] <= next_mctrl[t];
        act[t] <= next_act[t];
        capc[t] <= next_capc[t];
        match[t] <= next_match[t];
      end
    end
  end

  // first two instances are wide, last two narrow
  for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
    cfg_t cfg;
    edge_t ce, pe;
    logic hit;
    assign hit = (tsel == 2'(t));
    assign cfg = '{ctrl: ctrl[t], prescale: presc[t], mctrl: mctrl[t],
                   act: act[t], capc: capc[t], match: match[t]};
    assign ce = '{rise: cnt_s2[t] & ~cnt_prev[t], fall: ~cnt_s2[t] & cnt_prev[t]};
    assign pe = '{rise: cap_s2[t] & ~cap_prev[t], fall: ~cap_s2[t] & cap_prev[t]};
    ctm_unit #(.W(t < 2 ? 32 : 16)) u_unit ( // see RULE1
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cfg(cfg),
      .wr_cnt(wr && hit && off == OFS_COUNT),
      .wr_ext(wr && hit && off == OFS_EXTC),
      .wr_ctrl(wr && hit && off == OFS_CTRL),
      .clr_flags((wr && hit && off == OFS_FLAGS) ? wdata[4:0] : 5'h00), // see RULE11
      .wdata(wdata),
      .cnt_edge(ce),
      .cap_edge(pe),
      .cnt(cnt[t]),
      .pcnt(pcnt[t]),
      .capt(capt[t]),
      .flags(flags[t]),
      .mout(mout[t]),
      .halted(halted[t]),
      .tick(tick[t]),
      .mhit(mhit[t])
    );
    assign match_out[4*t +: 4] = mout[t];
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0;
    if (rd) begin
      case (off)
        OFS_CTRL: next_rdata = {26'h0, halted[tsel], ctrl[tsel]};
        OFS_FLAGS: next_rdata = {27'h0, flags[tsel]};
        OFS_COUNT: next_rdata = cnt[tsel];
        OFS_PRESC: next_rdata = narrow ? {16'h0, presc[tsel][15:0]} : presc[tsel]; // see RULE1
        OFS_MCTRL: next_rdata = {20'h0, mctrl[tsel]};
        OFS_EXTC: next_rdata = {20'h0, act[tsel], mout[tsel]};
        OFS_CAPC: next_rdata = {27'h0, capc[tsel]};
        OFS_CAPTURE: next_rdata = capt[tsel];
        OFS_PCOUNT: next_rdata = pcnt[tsel];
        default: begin
          if (off[5:4] == OFS_MATCH0[5:4]) begin
            next_rdata = narrow ? {16'h0, match[tsel][off[3:2]][15:0]} : match[tsel][off[3:2]]; // see RULE1
          end
        end
      endcase
    end
    for (int t = 0; t < NUM_TMR; t++) begin
      next_irq[t] = |flags[t];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h0;
      irq <= 4'h0;
    end else begin
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // checks on instances 0 and 1 (wide) and instances 2 and 3 (narrow)
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic quiet0, cap_any0, clr_any0;
  assign quiet0 = !(wr && tsel == 2'h0);
  assign cap_any0 = (capc[0][CAP_RISE] & cap_s2[0] & ~cap_prev[0]) |
                    (capc[0][CAP_FALL] & ~cap_s2[0] & cap_prev[0]);
  assign clr_any0 = (capc[0][CLR_RISE] & cap_s2[0] & ~cap_prev[0]) |
                    (capc[0][CLR_FALL] & ~cap_s2[0] & cap_prev[0]);
  // timer 1 helpers: writes and capture clears legally move its count
  logic quiet1, clr_any1;
  assign quiet1 = !(wr && tsel == 2'h1);
  assign clr_any1 = (capc[1][CLR_RISE] & cap_s2[1] & ~cap_prev[1]) |
                    (capc[1][CLR_FALL] & ~cap_s2[1] & cap_prev[1]);

  property p_narrow;
    cnt[2][31:16] == 16'h0 && capt[2][31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow count exceeds 16 bits"); // see RULE1

  property p_presc;
    (quiet0 && !clr_any0 && !ctrl[0][CTRL_HOLD] && !ctrl[0][CTRL_CNTMODE] && pcnt[0] != presc[0])
      |=> $stable(cnt[0]);
  endproperty
  a_presc: assert property (p_presc) else $error("count moved before prescaler rolled"); // see RULE2

  property p_cntmode;
    (quiet1 && !clr_any1 && !ctrl[1][CTRL_HOLD] && ctrl[1][CTRL_CNTMODE] && cnt_s2[1] == cnt_prev[1])
      |=> $stable(cnt[1]);
  endproperty
  a_cntmode: assert property (p_cntmode) else $error("counter moved without pin edge"); // see RULE3

  property p_mirq;
    (mhit[0][0] && mctrl[0][MC_IRQ]) |=> flags[0][0] ##1 irq[0];
  endproperty
  a_mirq: assert property (p_mirq) else $error("match flag or request missing"); // see RULE4

  property p_stop;
    (halted[1] && quiet1 && !clr_any1 && !ctrl[1][CTRL_HOLD]) |=> $stable(cnt[1]) && halted[1];
  endproperty
  a_stop: assert property (p_stop) else $error("halted counter moved"); // see RULE5

  property p_rst;
    (mhit[0][0] && mctrl[0][MC_RST] && !(|(mhit[0] & {mctrl[0][11], mctrl[0][8], mctrl[0][5], mctrl[0][2]}))
      && quiet0) |=> cnt[0] == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset on match failed"); // see RULE6

  property p_toggle;
    (mhit[3][2] && act[3][5:4] == ACT_TOGGLE && !(wr && tsel == 2'h3)) |=> match_out[14] != $past(match_out[14]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match output did not toggle"); // see RULE7

  property p_cap;
    cap_any0 |=> capt[0] == $past(cnt[0]);
  endproperty
  a_cap: assert property (p_cap) else $error("capture missed count"); // see RULE8

  property p_capirq;
    (cap_any0 && capc[0][CAP_IRQ]) |=> flags[0][FLAG_CAP] ##1 irq[0];
  endproperty
  a_capirq: assert property (p_capirq) else $error("capture flag missing"); // see RULE9

  property p_clr;
    (clr_any0 && quiet0) |=> cnt[0] == 32'h0 && pcnt[0] == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("capture clear failed"); // see RULE10

  property p_sticky;
    (flags[0][0] && !(wr && tsel == 2'h0 && off == OFS_FLAGS && wdata[0])) |=> flags[0][0] [*1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // see RULE11

  property p_wrap;
    (tick[2] && cnt[2] == 32'h0000ffff && mctrl[2] == 12'h000 && !(wr && tsel == 2'h2))
      |=> cnt[2] == 32'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("narrow counter did not wrap"); // see RULE12

  property p_pscl;
    (tick[0] && !ctrl[0][CTRL_CNTMODE]) |=> pcnt[0] == 32'h0;
  endproperty
  a_pscl: assert property (p_pscl) else $error("prescaler did not restart after a step"); // see RULE2

  property p_stopval;
    (mhit[1][1] && mctrl[1][MC_STRIDE+MC_STOP] && quiet1 && !clr_any1)
      |=> halted[1] && cnt[1] == $past(cnt[1]);
  endproperty
  a_stopval: assert property (p_stopval) else $error("stop on match did not hold the count"); // see RULE5

  property p_irq;
    irq[0] == ($past(flags[0]) != 5'h00);
  endproperty
  a_irq: assert property (p_irq) else $error("request does not follow the flags"); // see RULE4

  property p_rdidle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data stood without a read");

  property p_narrowrd;
    (rd && narrow && (off == OFS_PRESC || off[5:4] == OFS_MATCH0[5:4]))
      |=> rdata[31:16] == 16'h0;
  endproperty
  a_narrowrd: assert property (p_narrowrd) else $error("narrow register read upper bits"); // see RULE1

  property p_hold;
    ctrl[2][CTRL_HOLD] |=> cnt[2] == 32'h0 && pcnt[2] == 32'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold did not force count to zero");

  c_match: cover property (mhit[0][0] ##1 irq[0]);
  c_capture: cover property (cap_any0 ##1 flags[0][FLAG_CAP]);
  c_halt: cover property ($rose(halted[1]));
  c_wrap: cover property (tick[2] && cnt[2] == 32'h0000ffff);
  c_hold: cover property (ctrl[2][CTRL_HOLD] ##1 cnt[2] == 32'h0);
endmodule : ctm_top

// File: dv/match_capture_counter_timer_bench.sv
// self-checking bench for the four counter/timers
`timescale 1ns/10ps
module match_capture_counter_timer_bench;
  import ctm_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0] cnt_pin = 4'h0;
  logic [3:0] cap_pin = 4'h0;
  logic [15:0] match_out;
  logic [3:0] irq;
  int failures = 0;
  int checked = 0;
  logic [31:0] d;

  always #4 core_clk = ~core_clk;

  ctm_top i_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .cnt_pin(cnt_pin),
    .cap_pin(cap_pin),
    .match_out(match_out),
    .irq(irq)
  );

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // one-cycle write strobe, released on the next edge
  task automatic wr_reg(input logic [1:0] t, input logic [5:0] o, input logic [31:0] v);
    @(posedge core_clk);
    addr <= {t, o};
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] t, input logic [5:0] o, output logic [31:0] v);
    @(posedge core_clk);
    addr <= {t, o};
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic wait_irq(input int t);
    int n;
    n = 0;
    while (irq[t] !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (irq[t] !== 1'b1) begin
      failures++;
      $display("ERROR %0t: interrupt never rose", $time);
      tally_and_finish();
    end
  endtask : wait_irq

  task automatic t_reset_map;
    for (int t = 0; t < 4; t++) begin
      rd_reg(t[1:0], OFS_CTRL, d);
      chk(d, 32'h0, "control after reset");
    end
    rd_reg(2'h3, OFS_COUNT, d);
    chk(d, 32'h0, "count after reset");
    rd_reg(2'h0, 6'h3c, d);
    chk(d, 32'h0, "unmapped read");
    chk({28'h0, irq}, 32'h0, "irq after reset");
  endtask : t_reset_map

  task automatic t_widths;
    wr_reg(2'h0, OFS_PRESC, 32'hffffffff);
    rd_reg(2'h0, OFS_PRESC, d);
    chk(d, 32'hffffffff, "wide prescaler");
    wr_reg(2'h2, OFS_PRESC, 32'hffffffff);
    rd_reg(2'h2, OFS_PRESC, d);
    chk(d, 32'h0000ffff, "narrow prescaler");
    wr_reg(2'h2, OFS_MATCH0, 32'h00012345);
    rd_reg(2'h2, OFS_MATCH0, d);
    chk(d, 32'h00002345, "narrow match");
    wr_reg(2'h0, OFS_PRESC, 32'h0);
    wr_reg(2'h2, OFS_PRESC, 32'h0);
    wr_reg(2'h2, OFS_MATCH0, 32'h0);
  endtask : t_widths

  task automatic t_wrap;
    wr_reg(2'h2, OFS_COUNT, 32'h0000fffe);
    wr_reg(2'h2, OFS_CTRL, 32'h1);
    cyc(6);
    rd_reg(2'h2, OFS_COUNT, d);
    chk({31'h0, d < 32'h20}, 32'h1, "16-bit count wrapped");
    wr_reg(2'h2, OFS_CTRL, 32'h3);
    cyc(2);
    rd_reg(2'h2, OFS_COUNT, d);
    chk(d, 32'h0, "hold forces count to zero");
    wr_reg(2'h2, OFS_CTRL, 32'h0);
  endtask : t_wrap

  task automatic t_reset_match;
    wr_reg(2'h0, OFS_PRESC, 32'h1);
    wr_reg(2'h0, OFS_MATCH0, 32'h2);
    wr_reg(2'h0, OFS_MCTRL, 32'h3);
    wr_reg(2'h0, OFS_CTRL, 32'h1);
    wait_irq(0);
    rd_reg(2'h0, OFS_COUNT, d);
    chk({31'h0, d <= 32'h2}, 32'h1, "count returned to zero");
    rd_reg(2'h0, OFS_FLAGS, d);
    chk(d, 32'h1, "match flag");
    wr_reg(2'h0, OFS_CTRL, 32'h0);
    cyc(4);
    chk({31'h0, irq[0]}, 32'h1, "flag sticky");
    wr_reg(2'h0, OFS_FLAGS, 32'h1);
    cyc(3);
    chk({31'h0, irq[0]}, 32'h0, "flag cleared");
  endtask : t_reset_match

  task automatic t_stop;
    wr_reg(2'h1, OFS_MATCH0 + 6'h4, 32'h5);
    wr_reg(2'h1, OFS_MCTRL, 32'h20);
    wr_reg(2'h1, OFS_CTRL, 32'h1);
    cyc(20);
    rd_reg(2'h1, OFS_COUNT, d);
    chk(d, 32'h5, "count held at match");
    rd_reg(2'h1, OFS_CTRL, d);
    chk(d, 32'h21, "halted shown");
  endtask : t_stop

  task automatic t_count_mode;
    wr_reg(2'h1, OFS_CTRL, 32'h0);
    wr_reg(2'h1, OFS_MCTRL, 32'h0);
    wr_reg(2'h1, OFS_COUNT, 32'h0);
    wr_reg(2'h1, OFS_CTRL, 32'h0d);
    // pulses long enough for the two-stage synchroniser
    repeat (3) begin
      @(posedge core_clk);
      cnt_pin[1] <= 1'b1;
      cyc(5);
      cnt_pin[1] <= 1'b0;
      cyc(5);
    end
    cyc(4);
    rd_reg(2'h1, OFS_COUNT, d);
    chk(d, 32'h3, "rising edges counted");
    wr_reg(2'h1, OFS_CTRL, 32'h15);
    @(posedge core_clk);
    cnt_pin[1] <= 1'b1;
    cyc(5);
    cnt_pin[1] <= 1'b0;
    cyc(8);
    rd_reg(2'h1, OFS_COUNT, d);
    chk(d, 32'h4, "falling edge counted, rising ignored");
    wr_reg(2'h1, OFS_CTRL, 32'h0);
  endtask : t_count_mode

  task automatic t_outputs;
    wr_reg(2'h3, OFS_EXTC, 32'h0000036a);
    cyc(2);
    chk({28'h0, match_out[15:12]}, 32'ha, "outputs set directly");
    for (int i = 0; i < 4; i++) begin
      wr_reg(2'h3, OFS_MATCH0 + 6'(4 * i), 32'h3);
    end
    wr_reg(2'h3, OFS_COUNT, 32'h0);
    wr_reg(2'h3, OFS_CTRL, 32'h1);
    cyc(20);
    chk({28'h0, match_out[15:12]}, 32'hd, "high, low, toggle, none");
    rd_reg(2'h3, OFS_EXTC, d);
    chk(d, 32'h0000036d, "output state and actions read back");
    wr_reg(2'h3, OFS_CTRL, 32'h0);
  endtask : t_outputs

  task automatic t_capture;
    wr_reg(2'h0, OFS_MCTRL, 32'h0);
    wr_reg(2'h0, OFS_PRESC, 32'h0);
    wr_reg(2'h0, OFS_CAPC, 32'h0e);
    wr_reg(2'h0, OFS_FLAGS, 32'h1f);
    wr_reg(2'h0, OFS_COUNT, 32'h00001000);
    wr_reg(2'h0, OFS_CTRL, 32'h1);
    @(posedge core_clk);
    cap_pin[0] <= 1'b1;
    cyc(10);
    cap_pin[0] <= 1'b0;
    cyc(8);
    // pulse width seen as cleared count, within one cycle of slack
    rd_reg(2'h0, OFS_CAPTURE, d);
    chk({31'h0, d >= 32'h9 && d <= 32'hb}, 32'h1, "pulse width captured");
    rd_reg(2'h0, OFS_FLAGS, d);
    chk({31'h0, d[FLAG_CAP]}, 32'h1, "capture flag");
    chk({31'h0, irq[0]}, 32'h1, "capture interrupt");
  endtask : t_capture

  initial begin
    #(100000 * 8);
    failures++;
    $display("ERROR %0t: run limit reached", $time);
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset_map();
    t_widths();
    t_wrap();
    t_reset_match();
    t_stop();
    t_count_mode();
    t_outputs();
    t_capture();
    tally_and_finish();
  end
endmodule : match_capture_counter_timer_bench
